// [irwc_top.sv]
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module irwc_top
  import irwc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic streaming,
  input wire logic [15:0] line_index,
  output irwc_geom_t geom,
  output irwc_mode_t mode,
  output logic [3:0] line_skip,
  output logic mirror_h,
  output logic mirror_v,
  output logic line_fast,
  output logic line_keep,
  output logic [7:0] pixel_format
);
  // checks shared by write filter and consistency check
  function automatic logic geom_ok(input irwc_geom_t g);
    geom_ok = (g.width >= 16'(IRWC_MIN_W)) && (g.width <= 16'(IRWC_SENSOR_W))
      && (g.height >= 16'(IRWC_MIN_H)) && (g.height <= 16'(IRWC_SENSOR_H))
      && (g.width[1:0] == 2'h0) && (g.height[0] == 1'b0)
      && (g.start_h[1:0] == 2'h0) && (g.start_v[0] == 1'b0)
      && ({1'b0, g.start_h} + {1'b0, g.width} <= 17'(IRWC_SENSOR_W))
      && ({1'b0, g.start_v} + {1'b0, g.height} <= 17'(IRWC_SENSOR_H));
  endfunction : geom_ok

  function automatic logic skip_ok(input logic [31:0] v);
    skip_ok = (v == 32'h1) || (v == 32'h2) || (v == 32'h4) || (v == 32'h8);
  endfunction : skip_ok

  // stored state
  irwc_geom_t win, next_win;
  logic [3:0] skip, next_skip;
  logic mir_h, next_mir_h, mir_v, next_mir_v;
  logic [31:0] user_id, next_user_id;
  logic bulk, next_bulk;
  logic valid, next_valid;
  // bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  logic do_write;
  logic [31:0] wval;
  irwc_geom_t cand;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // write path: capture address and data in any order, then apply
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_win = win;
    next_skip = skip;
    next_mir_h = mir_h;
    next_mir_v = mir_v;
    next_user_id = user_id;
    next_bulk = bulk;
    next_valid = valid;
    cand = win;
    wval = 32'h0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = next_aw_held && next_w_held && !bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = IRWC_RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        wval[i*8 +: 8] = next_w_strb[i] ? next_w_data[i*8 +: 8] : 8'h00;
      end
      case (next_aw_addr)
        IRWC_A_WIN_W, IRWC_A_WIN_H, IRWC_A_START_H, IRWC_A_START_V: begin
          if (next_aw_addr == IRWC_A_WIN_W) cand.width = wval[15:0];
          if (next_aw_addr == IRWC_A_WIN_H) cand.height = wval[15:0];
          if (next_aw_addr == IRWC_A_START_H) cand.start_h = wval[15:0];
          if (next_aw_addr == IRWC_A_START_V) cand.start_v = wval[15:0];
          // frozen while streaming; bad values keep old contents, but in bulk mode only nonzero upper bits are refused
          if (streaming) begin
            next_bresp = IRWC_RESP_SLVERR;
          end else if ((wval[31:16] != 16'h0) || (!bulk && !geom_ok(cand))) begin
            next_bresp = IRWC_RESP_SLVERR;
          end else begin
            next_win = cand;
          end
        end
        IRWC_A_SKIP: begin
          if (streaming || !skip_ok(wval)) begin
            next_bresp = IRWC_RESP_SLVERR;
          end else begin
            next_skip = wval[3:0];
          end
        end
        IRWC_A_MIRROR: begin
          next_mir_h = wval[0];
          next_mir_v = wval[1];
        end
        IRWC_A_USER_ID: next_user_id = wval;
        IRWC_A_CMD: begin
          if (wval[IRWC_CMD_BEGIN]) next_bulk = 1'b1;
          if (wval[IRWC_CMD_END]) next_bulk = 1'b0;
          if (wval[IRWC_CMD_CHECK]) begin
            next_valid = geom_ok(win) && skip_ok({28'h0, skip});
          end
        end
        default: next_bresp = IRWC_RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // read path, one cycle answer
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = IRWC_RESP_OKAY;
      case (s_axi_araddr)
        IRWC_A_SENS_W, IRWC_A_MAX_W: next_rdata = 32'(IRWC_SENSOR_W);
        IRWC_A_SENS_H, IRWC_A_MAX_H: next_rdata = 32'(IRWC_SENSOR_H);
        IRWC_A_WIN_W: next_rdata = {16'h0, win.width};
        IRWC_A_WIN_H: next_rdata = {16'h0, win.height};
        IRWC_A_START_H: next_rdata = {16'h0, win.start_h};
        IRWC_A_START_V: next_rdata = {16'h0, win.start_v};
        IRWC_A_SKIP: next_rdata = {28'h0, skip};
        IRWC_A_MIRROR: next_rdata = {30'h0, mir_v, mir_h};
        IRWC_A_USER_ID: next_rdata = user_id;
        IRWC_A_CMD: next_rdata = 32'h0;
        IRWC_A_STATUS: next_rdata = {30'h0, bulk, valid};
        IRWC_A_FORMAT: next_rdata = {24'h0, IRWC_FMT_MONO_8BIT_FORMAT};
        default: begin
          next_rdata = 32'h0;
          next_rresp = IRWC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // register everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win <= '{width: 16'(IRWC_SENSOR_W), height: 16'(IRWC_SENSOR_H),
        start_h: 16'h0000, start_v: 16'h0000};
      skip <= 4'(IRWC_SKIP_RESET);
      mir_h <= 1'b0;
      mir_v <= 1'b0;
      user_id <= 32'h0000_0000;
      bulk <= 1'b0;
      valid <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      win <= next_win;
      skip <= next_skip;
      mir_h <= next_mir_h;
      mir_v <= next_mir_v;
      user_id <= next_user_id;
      bulk <= next_bulk;
      valid <= next_valid;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // readout mode: one rectangle, window and decimation exclusive
  logic is_window;
  irwc_mode_t next_mode;
  logic next_fast, next_keep;
  assign is_window = (win.width != 16'(IRWC_SENSOR_W)) || (win.height != 16'(IRWC_SENSOR_H));
  always_comb begin
    if (is_window) next_mode = IRWC_MODE_WINDOW;
    else if (skip != 4'h1) next_mode = IRWC_MODE_DECIM;
    else next_mode = IRWC_MODE_FULL;
    // fast for lines outside window, thinning in decimation
    next_fast = (next_mode == IRWC_MODE_WINDOW) && ((line_index < win.start_v)
      || ({1'b0, line_index} >= {1'b0, win.start_v} + {1'b0, win.height}));
    next_keep = !next_fast;
    if (next_mode == IRWC_MODE_DECIM) begin
      next_keep = ((line_index & 16'(skip - 4'h1)) == 16'h0);
    end
  end

  // registered readout controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= IRWC_MODE_FULL;
      geom <= '0;
      line_skip <= 4'h1;
      mirror_h <= 1'b0;
      mirror_v <= 1'b0;
      line_fast <= 1'b0;
      line_keep <= 1'b1;
      pixel_format <= 8'h00;
    end else begin
      mode <= next_mode;
      geom <= win;
      line_skip <= skip;
      mirror_h <= mir_h;
      mirror_v <= mir_v;
      line_fast <= next_fast;
      line_keep <= next_keep;
      pixel_format <= IRWC_FMT_MONO_8BIT_FORMAT;
    end
  end
endmodule : irwc_top

// [irwc_pkg.sv]
package irwc_pkg;
  localparam int unsigned IRWC_SENSOR_W = 2048;
  localparam int unsigned IRWC_SENSOR_H = 1088;
  localparam int unsigned IRWC_MIN_W = 64;
  localparam int unsigned IRWC_MIN_H = 64;
  localparam int unsigned IRWC_W_STEP = 4;
  localparam int unsigned IRWC_H_STEP = 2;
  localparam int unsigned IRWC_SKIP_RESET = 1;
  localparam logic [7:0] IRWC_FMT_MONO_8BIT_FORMAT = 8'h01;
  // byte offsets
  localparam logic [7:0] IRWC_A_SENS_W = 8'h00;
  localparam logic [7:0] IRWC_A_SENS_H = 8'h04;
  localparam logic [7:0] IRWC_A_MAX_W = 8'h08;
  localparam logic [7:0] IRWC_A_MAX_H = 8'h0C;
  localparam logic [7:0] IRWC_A_WIN_W = 8'h10;
  localparam logic [7:0] IRWC_A_WIN_H = 8'h14;
  localparam logic [7:0] IRWC_A_START_H = 8'h18;
  localparam logic [7:0] IRWC_A_START_V = 8'h1C;
  localparam logic [7:0] IRWC_A_SKIP = 8'h20;
  localparam logic [7:0] IRWC_A_MIRROR = 8'h24;
  localparam logic [7:0] IRWC_A_USER_ID = 8'h28;
  localparam logic [7:0] IRWC_A_CMD = 8'h2C;
  localparam logic [7:0] IRWC_A_STATUS = 8'h30;
  localparam logic [7:0] IRWC_A_FORMAT = 8'h34;
  // command bits in IRWC_A_CMD
  localparam int unsigned IRWC_CMD_BEGIN = 0;
  localparam int unsigned IRWC_CMD_END = 1;
  localparam int unsigned IRWC_CMD_CHECK = 2;
  localparam logic [1:0] IRWC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRWC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {IRWC_MODE_FULL, IRWC_MODE_WINDOW, IRWC_MODE_DECIM} irwc_mode_t;
  typedef struct packed {
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] start_h;
    logic [15:0] start_v;
  } irwc_geom_t;
endpackage : irwc_pkg

// [irwc_top_sva.sv]
`timescale 1ns/10ps
module irwc_top_sva
  import irwc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic streaming,
  input wire logic [15:0] line_index,
  input wire irwc_geom_t geom,
  input wire irwc_mode_t mode,
  input wire logic [3:0] line_skip,
  input wire logic mirror_h,
  input wire logic mirror_v,
  input wire logic line_fast,
  input wire logic line_keep,
  input wire logic [7:0] pixel_format
);
  logic exp_fast, exp_keep, next_exp_fast, next_exp_keep;
  // expected line class from this cycle's inputs
  always_comb begin
    next_exp_fast = mode == IRWC_MODE_WINDOW &&
      (line_index < geom.start_v || line_index >= geom.start_v + geom.height);
    next_exp_keep = line_index % {12'h000, line_skip} == 16'h0000;
  end
  // registered to line up with the outputs
  always_ff @(posedge aclk) begin
    exp_fast <= next_exp_fast;
    exp_keep <= next_exp_keep;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_fmt; $past(aresetn) |-> pixel_format == IRWC_FMT_MONO_8BIT_FORMAT; endproperty
  a_fmt: assert property (p_fmt) else $error("pixel format not mono");
  property p_skip; line_skip inside {4'h1, 4'h2, 4'h4, 4'h8}; endproperty
  a_skip: assert property (p_skip) else $error("line skip out of set");
  property p_gfrz; $past(streaming, 2) && $past(streaming) |-> $stable(geom); endproperty
  a_gfrz: assert property (p_gfrz) else $error("window changed while streaming");
  property p_sfrz; $past(streaming, 2) && $past(streaming) |-> $stable(line_skip); endproperty
  a_sfrz: assert property (p_sfrz) else $error("skip changed while streaming");
  property p_rst;
    $rose(aresetn) |=> geom.width == 16'(IRWC_SENSOR_W) && geom.height == 16'(IRWC_SENSOR_H);
  endproperty
  a_rst: assert property (p_rst) else $error("window not full after reset");
  property p_mir; $rose(aresetn) |-> !mirror_h && !mirror_v; endproperty
  a_mir: assert property (p_mir) else $error("mirror set after reset");
  property p_fast; $past(aresetn) && $stable(mode) && $stable(geom) |-> line_fast == exp_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("line speed class wrong");
  property p_keep;
    $past(aresetn) && $stable(mode) && $stable(line_skip) && mode != IRWC_MODE_WINDOW
      |-> line_keep == exp_keep;
  endproperty
  a_keep: assert property (p_keep) else $error("line thinning wrong");
endmodule : irwc_top_sva

// [irwc_top_test.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module irwc_top_test;
  import irwc_pkg::*;
  localparam logic [1:0] OK = IRWC_RESP_OKAY, ER = IRWC_RESP_SLVERR;
  localparam logic [31:0] RV [14] = '{32'h800, 32'h440, 32'h800, 32'h440, 32'h800, 32'h440,
    32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
  logic aclk = 1'b0, aresetn = 1'b0, streaming = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [15:0] line_index = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mirror_h, mirror_v, line_fast, line_keep;
  logic [1:0] s_axi_bresp, s_axi_rresp, eb;
  logic [31:0] s_axi_rdata, sk, u;
  logic [7:0] pixel_format;
  logic [3:0] line_skip;
  logic [33:0] e;
  irwc_geom_t geom;
  irwc_mode_t mode;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  irwc_top dut (.*);
  always #2 aclk = ~aclk;
  // random line position every cycle
  always @(posedge aclk) line_index <= 16'($urandom_range(1199));
  // response watcher against the expectation queues
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, s_axi_bresp)
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rq.pop_front();
      `CHK("rresp", e[33:32], s_axi_rresp)
      `CHK("rdata", e[31:0], s_axi_rdata)
    end
  end
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad, wd;
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad || s_axi_awready === 1'b1;
      wd = wd || s_axi_wready === 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask : rd
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
      input logic [31:0] rb);
    wr(a, d, r);
    rd(a, rb, OK);
  endtask : wrrd
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask : fin
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    void'($urandom(32'h862b));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) rd(8'(4 * i), RV[i], OK);
    rd(8'h40, 32'h0, ER);
    wr(8'h40, 32'h1, ER);
    fin("reset");
    wrrd(IRWC_A_WIN_W, 32'h42, ER, 32'h800);
    wrrd(IRWC_A_WIN_W, 32'h3C, ER, 32'h800);
    wrrd(IRWC_A_WIN_W, 32'h400, OK, 32'h400);
    wrrd(IRWC_A_START_H, 32'h402, ER, 32'h0);
    wrrd(IRWC_A_START_H, 32'h404, ER, 32'h0);
    wrrd(IRWC_A_START_H, 32'h400, OK, 32'h400);
    wrrd(IRWC_A_WIN_W, 32'h404, ER, 32'h400);
    wrrd(IRWC_A_WIN_H, 32'h41, ER, 32'h440);
    wrrd(IRWC_A_WIN_H, 32'h40, OK, 32'h40);
    wrrd(IRWC_A_START_V, 32'h401, ER, 32'h0);
    wrrd(IRWC_A_START_V, 32'h400, OK, 32'h400);
    wrrd(IRWC_A_WIN_H, 32'h42, ER, 32'h40);
    wr(IRWC_A_CMD, 32'h4, OK);
    rd(IRWC_A_STATUS, 32'h1, OK);
    `CHK("mode", IRWC_MODE_WINDOW, mode)
    fin("window");
    // skip register still holds its reset value before the first good write
    sk = 32'(IRWC_SKIP_RESET);
    for (int i = 0; i < 10; i++) begin
      if (i inside {1, 2, 4, 8}) sk = 32'(i);
      wrrd(IRWC_A_SKIP, 32'(i), (i inside {1, 2, 4, 8}) ? OK : ER, sk);
    end
    wr(IRWC_A_START_H, 32'h0, OK);
    wr(IRWC_A_START_V, 32'h0, OK);
    wr(IRWC_A_WIN_W, 32'h800, OK);
    wr(IRWC_A_WIN_H, 32'h440, OK);
    repeat (40) @(posedge aclk);
    `CHK("mode", IRWC_MODE_DECIM, mode)
    `CHK("line_skip", 4'h8, line_skip)
    fin("skip");
    streaming <= 1'b1;
    wrrd(IRWC_A_WIN_W, 32'h400, ER, 32'h800);
    wrrd(IRWC_A_SKIP, 32'h2, ER, 32'h8);
    wrrd(IRWC_A_MIRROR, 32'h3, OK, 32'h3);
    `CHK("mirror_h", 1'b1, mirror_h)
    `CHK("mirror_v", 1'b1, mirror_v)
    streaming <= 1'b0;
    u = $urandom;
    wrrd(IRWC_A_USER_ID, u, OK, u);
    fin("stream");
    wr(IRWC_A_CMD, 32'h1, OK);
    wr(IRWC_A_WIN_W, 32'h400, OK);
    wr(IRWC_A_START_H, 32'h404, OK);
    wr(IRWC_A_CMD, 32'h4, OK);
    rd(IRWC_A_STATUS, 32'h2, OK);
    wr(IRWC_A_CMD, 32'h3, OK);
    rd(IRWC_A_STATUS, 32'h0, OK);
    wr(IRWC_A_START_H, 32'h404, ER);
    wrrd(IRWC_A_START_H, 32'h0, OK, 32'h0);
    wr(IRWC_A_CMD, 32'h4, OK);
    rd(IRWC_A_STATUS, 32'h1, OK);
    fin("bulk");
    // let the watcher take the last answer before closing
    repeat (2) @(posedge aclk);
    `CHK("pixel_format", IRWC_FMT_MONO_8BIT_FORMAT, pixel_format)
    `CHK("wq_left", 0, wq.size())
    `CHK("rq_left", 0, rq.size())
    wrap_up();
  end
endmodule : irwc_top_test
bind irwc_top irwc_top_sva chk (.*);
